// *** pkg/sbi_pkg.sv ***
// constants for the serial bit-addressed port and interrupt block
// assumes a single clock domain shared with the bus master logic
package sbi_pkg;
	localparam int SEL_W = 5;
	localparam int PORT_W = 16;
	localparam int TIMER_W = 14;
	localparam int LVL_W = 4;
	// bit addresses in the 32-bit space
	localparam logic [4:0] BIT_MODE = 5'h00;
	localparam logic [4:0] BIT_TMR3 = 5'h03;
	localparam logic [4:0] BIT_SOFT_RST = 5'h0F;
	localparam logic [4:0] BIT_PORT_LO = 5'h10;
	localparam logic [4:0] BIT_PORT_HI = 5'h1F;
	// word offset of the port bits, twice the bit address
	localparam logic [11:0] PORT_BASE_OFFSET = 12'h020;
	// mode encodings of the mode control bit
	localparam logic MODE_INT = 1'b0;
	localparam logic MODE_CLOCK = 1'b1;
	// timer decrement prescale in ref_clk cycles
	localparam int TMR_PRESCALE = 64;
	localparam logic [5:0] PRE_LAST = 6'(TMR_PRESCALE - 1);
	localparam logic [TIMER_W-1:0] TMR_ZERO = 14'h0000;
	localparam logic [TIMER_W-1:0] TMR_ONE = 14'h0001;
	localparam logic [LVL_W-1:0] LVL_NONE = 4'h0;
endpackage : sbi_pkg

// *** rtl/sbi_port.sv ***
// serial bit-addressed port, interrupt mask and interval timer
// assumes bus strobes come from logic on ref_clk; pins and
// interrupt inputs are asynchronous and are synchronised here
`timescale 1ns/10ps
module sbi_port
	import sbi_pkg::*;
(
	// clock, reset, enable
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic clk_en,
	// serial bit bus
	input wire logic chip_sel_n,
	input wire logic [sbi_pkg::SEL_W-1:0] bit_select_inputs,
	input wire logic bit_wr,
	input wire logic bit_wr_data,
	output logic bit_rd_data,
	// port pins
	input wire logic [sbi_pkg::PORT_W-1:0] port_pins_in,
	output logic [sbi_pkg::PORT_W-1:0] port_pins_out,
	output logic [sbi_pkg::PORT_W-1:0] port_pins_oe,
	// interrupt inputs, active low, index 0 unused
	input wire logic [15:1] irq_in_n,
	// interrupt request
	output logic request_output_pin_n,
	output logic [sbi_pkg::LVL_W-1:0] irq_level
);
	import sbi_pkg::*;

	typedef struct packed {
		logic [PORT_W-1:0] p_s1;
		logic [PORT_W-1:0] p_s2;
		logic [PORT_W-1:0] p_s3;
		logic [PORT_W-1:0] p_val;
		logic [15:1] i_s1;
		logic [15:1] i_s2;
		logic [15:1] i_s3;
		logic [15:1] i_val;
		logic mode;
		logic [15:1] mask;
		logic [PORT_W-1:0] dir;
		logic [PORT_W-1:0] pout;
		logic [TIMER_W-1:0] tload;
		logic [TIMER_W-1:0] tcnt;
		logic [5:0] pre;
		logic tflag;
		logic rd_bit;
		logic req_n;
		logic [LVL_W-1:0] lvl;
	} sbi_state_s;

	localparam sbi_state_s ST_RST = '{p_val: 16'hFFFF, p_s1: 16'hFFFF, p_s2: 16'hFFFF, p_s3: 16'hFFFF,
		i_val: 15'h7FFF, i_s1: 15'h7FFF,
		i_s2: 15'h7FFF, i_s3: 15'h7FFF, req_n: 1'b1, default: '0};

	sbi_state_s state_reg;
	sbi_state_s state_next;

	logic sel_active;
	logic wr_hit;
	logic rd_hit;
	logic timer_on;
	logic [15:1] irq_eff;
	logic [15:1] pending;
	logic [15:0] low_vec;
	logic [PORT_W-1:0] port_vec;
	logic [3:0] idx;
	logic tick;

	always_comb
	begin
		state_next = state_reg;
		sel_active = !chip_sel_n;
		wr_hit = sel_active && bit_wr;
		rd_hit = sel_active && !bit_wr;
		idx = bit_select_inputs[3:0];
		timer_on = state_reg.tload != TMR_ZERO;
		tick = timer_on && (state_reg.pre == PRE_LAST);

		// three-stage synchronisers, value taken when stages 2 and 3 agree
		state_next.p_s1 = port_pins_in;
		state_next.p_s2 = state_reg.p_s1;
		state_next.p_s3 = state_reg.p_s2;
		state_next.i_s1 = irq_in_n;
		state_next.i_s2 = state_reg.i_s1;
		state_next.i_s3 = state_reg.i_s2;
		for (int i = 0; i < PORT_W; i++)
		begin
			if (state_reg.p_s2[i] == state_reg.p_s3[i])
			begin
				state_next.p_val[i] = state_reg.p_s3[i];
			end
		end
		for (int i = 1; i < 16; i++)
		begin
			if (state_reg.i_s2[i] == state_reg.i_s3[i])
			begin
				state_next.i_val[i] = state_reg.i_s3[i];
			end
		end

		// read path, one bit per access
		low_vec = (state_reg.mode == MODE_CLOCK) ?
			{!state_reg.req_n, state_reg.tcnt, state_reg.mode} :
			{state_reg.i_val, state_reg.mode};
		for (int i = 0; i < PORT_W; i++)
		begin
			port_vec[i] = state_reg.dir[i] ? state_reg.pout[i] : state_reg.p_val[i];
		end
		if (rd_hit)
		begin
			state_next.rd_bit = bit_select_inputs[4] ? port_vec[idx] : low_vec[idx];
		end
		else
		begin
			state_next.rd_bit = 1'b0;
		end

		// timer countdown with reload
		if (timer_on)
		begin
			state_next.pre = tick ? 6'h00 : 6'(state_reg.pre + 6'h01);
		end
		if (tick)
		begin
			if (state_reg.tcnt == TMR_ZERO)
			begin
				state_next.tcnt = state_reg.tload;
			end
			else
			begin
				state_next.tcnt = TIMER_W'(state_reg.tcnt - TMR_ONE);
			end
		end

		// write path
		if (wr_hit)
		begin
			if (bit_select_inputs[4])
			begin
				state_next.dir[idx] = 1'b1;
				state_next.pout[idx] = bit_wr_data;
			end
			else if (bit_select_inputs == BIT_MODE)
			begin
				state_next.mode = bit_wr_data;
			end
			else if (state_reg.mode == MODE_INT)
			begin
				state_next.mask[idx] = bit_wr_data;
				if (bit_select_inputs == BIT_TMR3)
				begin
					state_next.tflag = 1'b0;
				end
			end
			else if (bit_select_inputs == BIT_SOFT_RST)
			begin
				if (!bit_wr_data)
				begin
					state_next.dir = '0;
				end
			end
			else
			begin
				state_next.tload[idx - 4'h1] = bit_wr_data;
				state_next.tcnt = state_next.tload;
				state_next.pre = 6'h00;
				state_next.tflag = 1'b0;
			end
		end

		// timer expiry, set wins over any clear above
		if (tick && state_reg.tcnt == TMR_ONE)
		begin
			state_next.tflag = 1'b1;
		end

		// request and priority, lowest level first
		irq_eff = ~state_reg.i_val;
		if (timer_on)
		begin
			irq_eff[3] = state_reg.tflag;
		end
		pending = irq_eff & state_reg.mask;
		state_next.req_n = !(|pending);
		state_next.lvl = LVL_NONE;
		for (int i = 15; i >= 1; i--)
		begin
			if (pending[i])
			begin
				state_next.lvl = LVL_W'(i);
			end
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			state_reg <= ST_RST;
		end
		else if (clk_en)
		begin
			state_reg <= state_next;
		end
	end

	assign bit_rd_data = state_reg.rd_bit;
	assign port_pins_out = state_reg.pout;
	assign port_pins_oe = state_reg.dir;
	assign request_output_pin_n = state_reg.req_n;
	assign irq_level = state_reg.lvl;

	// checks
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);

	sequence mode_clock_set_s;
		clk_en && !chip_sel_n && bit_wr && bit_select_inputs == BIT_MODE && bit_wr_data;
	endsequence

	sequence soft_rst_wr_s;
		clk_en && !chip_sel_n && bit_wr && bit_select_inputs == BIT_SOFT_RST && !bit_wr_data;
	endsequence

	dir_after_reset_a: assert property ($past(reset) |-> port_pins_oe == '0)
		else $error("port pins not inputs after reset");

	port_write_a: assert property (clk_en && !chip_sel_n && bit_wr && bit_select_inputs[4]
		|=> port_pins_oe[$past(bit_select_inputs[3:0])]
		&& port_pins_out[$past(bit_select_inputs[3:0])] == $past(bit_wr_data))
		else $error("port write did not drive pin");

	port_echo_a: assert property (clk_en && !chip_sel_n && !bit_wr && bit_select_inputs[4]
		&& port_pins_oe[bit_select_inputs[3:0]]
		|=> bit_rd_data == $past(port_pins_out[bit_select_inputs[3:0]])
		&& port_pins_oe == $past(port_pins_oe) && port_pins_out == $past(port_pins_out))
		else $error("output echo wrong or disturbed");

	soft_reset_a: assert property (mode_clock_set_s ##[1:3] (soft_rst_wr_s ##0 state_reg.mode == MODE_CLOCK)
		|=> port_pins_oe == '0)
		else $error("soft reset left outputs enabled");

	mask_write_a: assert property (clk_en && !chip_sel_n && bit_wr && bit_select_inputs != BIT_MODE
		&& !bit_select_inputs[4] && state_reg.mode == MODE_INT
		|=> state_reg.mask[$past(idx)] == $past(bit_wr_data))
		else $error("mask write not stored");

	req_read_a: assert property (clk_en && rd_hit && bit_select_inputs == BIT_SOFT_RST
		&& state_reg.mode == MODE_CLOCK |=> bit_rd_data == !$past(request_output_pin_n))
		else $error("request status read wrong");

	timer_expire_a: assert property (clk_en && tick && state_reg.tcnt == TMR_ONE
		|=> state_reg.tflag && state_reg.tcnt == TMR_ZERO)
		else $error("timer expiry missed");

	ext3_ignored_a: assert property (timer_on && !state_reg.tflag && state_reg.mask[3]
		&& state_reg.mask[15:4] == '0 && state_reg.mask[2:1] == '0
		&& !(clk_en && wr_hit) |=> request_output_pin_n || $past(clk_en) == 1'b0)
		else $error("external level 3 seen while timer runs");

	no_select_a: assert property (chip_sel_n |=> port_pins_oe == $past(port_pins_oe)
		&& port_pins_out == $past(port_pins_out) && state_reg.mask == $past(state_reg.mask))
		else $error("state changed without chip select");

	mode_write_a: assert property (clk_en && !chip_sel_n && bit_wr && bit_select_inputs == BIT_MODE
		|=> state_reg.mode == $past(bit_wr_data))
		else $error("mode bit not written");
endmodule : sbi_port

// *** tb/sbi_host.sv ***
// host model driving the serial bit bus, one bit per access
// assumes ref_clk from the bench; changes its lines on the falling edge
`timescale 1ns/10ps
module sbi_host (
	// clock and read data
	input wire logic ref_clk,
	input wire logic bit_rd_data,
	// bus lines
	output logic chip_sel_n,
	output logic [4:0] bit_select_inputs,
	output logic bit_wr,
	output logic bit_wr_data
);
	initial
	begin
		chip_sel_n = 1'h1;
		bit_select_inputs = 5'h00;
		bit_wr = 1'h0;
		bit_wr_data = 1'h0;
	end
	task automatic xfer(input logic [4:0] a, input logic w, input logic d, output logic q);
		@(negedge ref_clk);
		chip_sel_n = 1'h0;
		bit_select_inputs = a;
		bit_wr = w;
		bit_wr_data = d;
		@(negedge ref_clk);
		q = bit_rd_data;
		chip_sel_n = 1'h1;
		bit_select_inputs = ~a;
		bit_wr = 1'h0;
		bit_wr_data = ~d;
	endtask : xfer
	task automatic ld(input logic [4:0] a, input logic [15:0] v, input int n);
		logic q;
		for (int i = 0; i < n; i++)
			xfer(a + 5'(i), 1'h1, (n <= 8) ? v[8 + i] : v[i], q);
	endtask : ld
	task automatic st(input logic [4:0] a, input int n, output logic [15:0] v);
		logic q;
		v = 16'h0000;
		for (int i = 0; i < n; i++)
		begin
			xfer(a + 5'(i), 1'h0, 1'h0, q);
			v[i] = q;
		end
	endtask : st
endmodule : sbi_host

// *** tb/serial_bit_io_interrupt_port_tb.sv ***
// self-checking bench for the serial bit port block
// assumes the host model in sbi_host and a 20 MHz ref_clk
`timescale 1ns/10ps
module serial_bit_io_interrupt_port_tb;
	import sbi_pkg::*;
	logic ref_clk, reset, clk_en, chip_sel_n, bit_wr, bit_wr_data, bit_rd_data, request_output_pin_n, b;
	logic [4:0] bit_select_inputs, n;
	logic [15:0] port_pins_in, port_pins_out, port_pins_oe, out_m, w, q;
	logic [15:1] irq_in_n;
	logic [3:0] irq_level;
	int fails, samples_checked;
	sbi_port dut (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .chip_sel_n(chip_sel_n),
		.bit_select_inputs(bit_select_inputs), .bit_wr(bit_wr), .bit_wr_data(bit_wr_data),
		.bit_rd_data(bit_rd_data), .port_pins_in(port_pins_in), .port_pins_out(port_pins_out),
		.port_pins_oe(port_pins_oe), .irq_in_n(irq_in_n), .request_output_pin_n(request_output_pin_n),
		.irq_level(irq_level));
	sbi_host host (.ref_clk(ref_clk), .bit_rd_data(bit_rd_data), .chip_sel_n(chip_sel_n),
		.bit_select_inputs(bit_select_inputs), .bit_wr(bit_wr), .bit_wr_data(bit_wr_data));
	initial
	begin
		ref_clk = 1'h0;
		forever #25 ref_clk = ~ref_clk;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic complete_run;
		$display("counts: fails=%0d samples_checked=%0d", fails, samples_checked);
		if (fails == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : complete_run
	task automatic settle(input int c);
		repeat (c) @(negedge ref_clk);
	endtask : settle
	initial
	begin
		reset = 1'h1;
		clk_en = 1'h1;
		port_pins_in = 16'hFFFF;
		irq_in_n = 15'h7FFF;
		void'($urandom(97156));
		settle(5);
		reset = 1'h0;
		settle(1);
		check(port_pins_oe, 16'h0000);
		check({15'h0000, request_output_pin_n}, 16'h0001);
		$display("test reset done");
		out_m = 16'($urandom);
		host.ld(BIT_PORT_LO, out_m, 16);
		check(port_pins_oe, 16'hFFFF);
		check(port_pins_out, out_m);
		port_pins_in = ~out_m;
		settle(4);
		host.st(BIT_PORT_LO, 16, q);
		check(q, out_m);
		check(port_pins_oe, 16'hFFFF);
		w = 16'($urandom);
		host.ld(BIT_PORT_LO, w, 8);
		out_m[7:0] = w[15:8];
		check(port_pins_out, out_m);
		$display("test port output done");
		host.xfer(BIT_MODE, 1'h1, 1'h1, b);
		host.xfer(BIT_SOFT_RST, 1'h1, 1'h0, b);
		check(port_pins_oe, 16'h0000);
		host.xfer(BIT_MODE, 1'h0, 1'h0, b);
		check({15'h0000, b}, 16'h0001);
		host.st(BIT_PORT_LO, 16, q);
		check(q, port_pins_in);
		$display("test soft reset done");
		n = 5'(4 + $urandom % 10);
		host.xfer(BIT_MODE, 1'h1, MODE_INT, b);
		host.xfer(n, 1'h1, 1'h1, b);
		irq_in_n[n] = 1'h0;
		settle(6);
		check({12'h000, irq_level}, {11'h000, n});
		host.xfer(n, 1'h0, 1'h0, b);
		check({15'h0000, b}, 16'h0000);
		host.xfer(n, 1'h1, 1'h0, b);
		settle(3);
		check({15'h0000, request_output_pin_n}, 16'h0001);
		irq_in_n[n] = 1'h1;
		$display("test interrupt done");
		host.xfer(BIT_TMR3, 1'h1, 1'h1, b);
		host.xfer(BIT_MODE, 1'h1, MODE_CLOCK, b);
		host.xfer(5'h01, 1'h1, 1'h0, b);
		host.xfer(5'h02, 1'h1, 1'h1, b);
		irq_in_n[3] = 1'h0;
		host.xfer(5'h02, 1'h0, 1'h0, b);
		check({15'h0000, b}, 16'h0001);
		settle(4);
		check({15'h0000, request_output_pin_n}, 16'h0001);
		for (int k = 0; request_output_pin_n !== 1'h0; k++)
		begin
			if (k == 400)
			begin
				fails++;
				complete_run();
			end
			settle(1);
		end
		check({12'h000, irq_level}, 16'h0003);
		host.xfer(BIT_SOFT_RST, 1'h0, 1'h0, b);
		check({15'h0000, b}, 16'h0001);
		$display("test timer done");
		host.xfer(BIT_PORT_HI, 1'h1, 1'h1, b);
		check(port_pins_oe, 16'h8000);
		reset = 1'h1;
		settle(2);
		reset = 1'h0;
		settle(1);
		check(port_pins_oe, 16'h0000);
		check({12'h000, irq_level}, 16'h0000);
		check({15'h0000, request_output_pin_n}, 16'h0001);
		$display("test mid reset done");
		complete_run();
	end
endmodule : serial_bit_io_interrupt_port_tb
